// ### hw/mpepr_pkg.sv
// package: register map, field layout and state types of the pwm event/preload register block
package mpepr_pkg;
   // register-file addresses
   localparam logic [7:0] ADDR_PENDING = 8'hf3;
   localparam logic [7:0] ADDR_TACHO_HIGH = 8'hf4;
   localparam logic [7:0] ADDR_TACHO_LOW = 8'hf5;
   localparam logic [7:0] ADDR_PWM_DIV = 8'hf6;
   localparam logic [7:0] ADDR_REP = 8'hf7;
   localparam logic [7:0] ADDR_W_HIGH = 8'hf8;
   localparam logic [7:0] ADDR_W_LOW = 8'hf9;
   localparam logic [7:0] ADDR_V_HIGH = 8'hfa;
   localparam logic [7:0] ADDR_V_LOW = 8'hfb;
   localparam logic [7:0] ADDR_U_HIGH = 8'hfc;
   localparam logic [7:0] ADDR_U_LOW = 8'hfd;
   localparam logic [7:0] ADDR_P0_HIGH = 8'hfe;
   localparam logic [7:0] ADDR_P0_LOW = 8'hff;
   // pending flag bit positions
   localparam int BIT_PERIOD = 7;
   localparam int BIT_CAPTURE = 6;
   localparam int BIT_OVERFLOW = 5;
   localparam int BIT_TRANSFER = 4;
   localparam int BIT_ZERO = 3;
   localparam int BIT_U = 2;
   localparam int BIT_V = 1;
   localparam int BIT_W = 0;
   // field masks of partly reserved registers
   localparam logic [7:0] MASK_TACHO_HIGH = 8'h0f;
   localparam logic [7:0] MASK_PHASE_LOW = 8'he0;
   localparam logic [7:0] MASK_P0_HIGH = 8'h03;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // software transfer enable bits: repetition, w, v, u, compare-0
   localparam int SEN_REP = 4;
   localparam int SEN_W = 3;
   localparam int SEN_V = 2;
   localparam int SEN_U = 1;
   localparam int SEN_P0 = 0;

   // live compare values seen by the counter logic
   typedef struct packed {
      logic [10:0] u;
      logic [10:0] v;
      logic [10:0] w;
      logic [9:0] p0;
   } mpepr_compare_t;

   // raw counter events from the counter section
   typedef struct packed {
      logic pwm_zero;
      logic period_match;
      logic u_match;
      logic v_match;
      logic w_match;
      logic tacho_capture;
      logic tacho_overflow;
   } mpepr_events_t;

   // transfer bookkeeping state
   typedef enum logic [1:0] {
      MPEPR_XF_IDLE = 2'b01,
      MPEPR_XF_LOAD = 2'b10
   } mpepr_xf_state_t;

   // complete block state
   typedef struct packed {
      logic [7:0] pending;
      logic [7:0] tacho_high;
      logic [7:0] tacho_low;
      logic [7:0] pwm_div;
      logic [7:0] update_period_count;
      logic [7:0] w_high;
      logic [7:0] w_low;
      logic [7:0] v_high;
      logic [7:0] v_low;
      logic [7:0] u_high;
      logic [7:0] u_low;
      logic [7:0] p0_high;
      logic [7:0] p0_low;
      logic [7:0] rep_count;
      logic [11:0] tacho_pre_cnt;
      logic [7:0] pwm_pre_cnt;
      logic tacho_tick;
      logic pwm_tick;
      logic transfer_pulse;
      mpepr_xf_state_t xf_state;
      mpepr_compare_t cmp;
      logic [7:0] rd_data;
   } mpepr_state_t;
endpackage

// ### hw/mpepr_top.sv
// event-pending, prescaler, repetition and compare-preload registers of the motor pwm controller
//
// Contract
// - compare-0 match sets period flag when enabled
// - tacho capture sets capture flag when enabled
// - tacho overflow sets overflow flag when enabled
// - preload transfer sets transfer flag when enabled
// - pwm counter zero sets zero flag when enabled
// - classical mode: phase match sets phase flag when enabled
// - zero-centred: only selected direction sets phase flags
// - software writes never set pending flags
// - written zero clears, written one keeps
// - tacho prescaler 12 bits, high nibble low byte
// - pwm prescaler divides by value plus one
// - repetition zero transfers on every counter zero
// - phase preloads 11 bits, low reserved bits
// - compare-0 preload 10 bits, high reserved bits
// - reset clears all these registers to zero
// - hardware mode: both zero reload, copy, event
// - software command copies only enabled preloads
`timescale 1ns/1ns
`default_nettype none
module mpepr_top
(
   input wire logic clk_sys_i, // internal core clock
   input wire logic reset_n_i, // system reset, active low
   // register-file port
   input wire logic [7:0] reg_addr_i, // register address
   input wire logic reg_wr_i, // byte write strobe
   input wire logic [7:0] reg_wdata_i, // write byte
   input wire logic reg_rd_i, // read strobe
   output logic [7:0] reg_rdata_o, // read byte, registered
   // control bits held by the neighbouring control/mask registers
   input wire logic pwm_enable_i, // pwm counter and prescaler running
   input wire logic tacho_enable_i, // tacho counter and prescaler running
   input wire logic counting_shape_select_i, // 0 classical, 1 zero-centred
   input wire logic direction_event_select_i, // 0 flag on up, 1 flag on down
   input wire logic counting_up_i, // counter direction status, 1 up
   input wire logic transfer_source_select_i, // 0 hardware, 1 software transfer
   input wire logic software_transfer_command_i, // one-cycle transfer command
   input wire logic [4:0] software_transfer_enables_i, // rep, w, v, u, compare-0
   input wire logic [7:0] event_enables_i, // per-flag enables, pending layout
   input wire mpepr_pkg::mpepr_events_t events_i, // raw counter events
   // outputs to the counter section
   output logic tacho_tick_o, // tacho counter clock enable pulse
   output logic pwm_tick_o, // pwm counter clock enable pulse
   output logic transfer_o, // preloads copied this cycle
   output mpepr_pkg::mpepr_compare_t compare_o, // live compare values
   output logic [7:0] event_pending_flags_o // pending flags for interrupt logic
);
   // ==========================================================
   // state
   mpepr_pkg::mpepr_state_t state_reg; // registered state
   mpepr_pkg::mpepr_state_t state_next; // next state
   logic [7:0] raw_set; // qualified event set vector
   logic phase_dir_ok; // direction filter for phase flags
   logic [11:0] tacho_div; // assembled tacho prescaler value
   logic hw_transfer; // hardware transfer condition
   logic sw_transfer; // software transfer command taken
   logic [7:0] wmask; // write-clear mask

   // ==========================================================
   // next-state logic
   always_comb
   begin
      state_next = state_reg;
      state_next.tacho_tick = 1'b0;
      state_next.pwm_tick = 1'b0;
      state_next.transfer_pulse = 1'b0;
      // tacho prescaler: 12-bit value, divide by value plus one
      tacho_div = {state_reg.tacho_high[3:0], state_reg.tacho_low};
      if (!tacho_enable_i)
      begin
         state_next.tacho_pre_cnt = 12'h000;
      end
      else if (state_reg.tacho_pre_cnt >= tacho_div)
      begin
         state_next.tacho_pre_cnt = 12'h000;
         state_next.tacho_tick = 1'b1;
      end
      else
      begin
         state_next.tacho_pre_cnt = state_reg.tacho_pre_cnt + 12'h001;
      end
      // pwm prescaler: divide by value plus one
      if (!pwm_enable_i)
      begin
         state_next.pwm_pre_cnt = 8'h00;
      end
      else if (state_reg.pwm_pre_cnt >= state_reg.pwm_div)
      begin
         state_next.pwm_pre_cnt = 8'h00;
         state_next.pwm_tick = 1'b1;
      end
      else
      begin
         state_next.pwm_pre_cnt = state_reg.pwm_pre_cnt + 8'h01;
      end
      // transfer decision
      hw_transfer = !transfer_source_select_i && pwm_enable_i && events_i.pwm_zero
         && (state_reg.rep_count == 8'h00);
      sw_transfer = transfer_source_select_i && software_transfer_command_i;
      case (state_reg.xf_state)
         mpepr_pkg::MPEPR_XF_IDLE:
         begin
            // count down repetition on each counter zero not transferring
            if (!transfer_source_select_i && pwm_enable_i && events_i.pwm_zero && !hw_transfer)
            begin
               state_next.rep_count = state_reg.rep_count - 8'h01;
            end
            if (hw_transfer)
            begin
               // reload repetition, copy all preloads
               state_next.rep_count = state_reg.update_period_count;
               state_next.cmp.w = {state_reg.w_high, state_reg.w_low[7:5]};
               state_next.cmp.v = {state_reg.v_high, state_reg.v_low[7:5]};
               state_next.cmp.u = {state_reg.u_high, state_reg.u_low[7:5]};
               state_next.cmp.p0 = {state_reg.p0_high[1:0], state_reg.p0_low};
               state_next.transfer_pulse = 1'b1;
               state_next.xf_state = mpepr_pkg::MPEPR_XF_LOAD;
            end
            else if (sw_transfer)
            begin
               // copy only the individually enabled preloads
               if (software_transfer_enables_i[mpepr_pkg::SEN_REP])
               begin
                  state_next.rep_count = state_reg.update_period_count;
               end
               if (software_transfer_enables_i[mpepr_pkg::SEN_W])
               begin
                  state_next.cmp.w = {state_reg.w_high, state_reg.w_low[7:5]};
               end
               if (software_transfer_enables_i[mpepr_pkg::SEN_V])
               begin
                  state_next.cmp.v = {state_reg.v_high, state_reg.v_low[7:5]};
               end
               if (software_transfer_enables_i[mpepr_pkg::SEN_U])
               begin
                  state_next.cmp.u = {state_reg.u_high, state_reg.u_low[7:5]};
               end
               if (software_transfer_enables_i[mpepr_pkg::SEN_P0])
               begin
                  state_next.cmp.p0 = {state_reg.p0_high[1:0], state_reg.p0_low};
               end
               state_next.transfer_pulse = 1'b1;
               state_next.xf_state = mpepr_pkg::MPEPR_XF_LOAD;
            end
         end
         mpepr_pkg::MPEPR_XF_LOAD:
         begin
            // one-cycle marker state, back to idle
            state_next.xf_state = mpepr_pkg::MPEPR_XF_IDLE;
         end
         default:
         begin
            state_next.xf_state = mpepr_pkg::MPEPR_XF_IDLE;
         end
      endcase
      // phase flags: classical any match, zero-centred chosen direction
      phase_dir_ok = !counting_shape_select_i
         || (counting_up_i != direction_event_select_i);
      raw_set = 8'h00;
      raw_set[mpepr_pkg::BIT_PERIOD] = events_i.period_match;
      raw_set[mpepr_pkg::BIT_CAPTURE] = events_i.tacho_capture;
      raw_set[mpepr_pkg::BIT_OVERFLOW] = events_i.tacho_overflow;
      raw_set[mpepr_pkg::BIT_TRANSFER] = state_reg.transfer_pulse;
      raw_set[mpepr_pkg::BIT_ZERO] = events_i.pwm_zero;
      raw_set[mpepr_pkg::BIT_U] = events_i.u_match && phase_dir_ok;
      raw_set[mpepr_pkg::BIT_V] = events_i.v_match && phase_dir_ok;
      raw_set[mpepr_pkg::BIT_W] = events_i.w_match && phase_dir_ok;
      raw_set = raw_set & event_enables_i;
      // register writes; pending clears on zero, never sets
      wmask = 8'hff;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            mpepr_pkg::ADDR_PENDING: wmask = reg_wdata_i;
            mpepr_pkg::ADDR_TACHO_HIGH: state_next.tacho_high = reg_wdata_i & mpepr_pkg::MASK_TACHO_HIGH;
            mpepr_pkg::ADDR_TACHO_LOW: state_next.tacho_low = reg_wdata_i;
            mpepr_pkg::ADDR_PWM_DIV: state_next.pwm_div = reg_wdata_i;
            mpepr_pkg::ADDR_REP: state_next.update_period_count = reg_wdata_i;
            mpepr_pkg::ADDR_W_HIGH: state_next.w_high = reg_wdata_i;
            mpepr_pkg::ADDR_W_LOW: state_next.w_low = reg_wdata_i & mpepr_pkg::MASK_PHASE_LOW;
            mpepr_pkg::ADDR_V_HIGH: state_next.v_high = reg_wdata_i;
            mpepr_pkg::ADDR_V_LOW: state_next.v_low = reg_wdata_i & mpepr_pkg::MASK_PHASE_LOW;
            mpepr_pkg::ADDR_U_HIGH: state_next.u_high = reg_wdata_i;
            mpepr_pkg::ADDR_U_LOW: state_next.u_low = reg_wdata_i & mpepr_pkg::MASK_PHASE_LOW;
            mpepr_pkg::ADDR_P0_HIGH: state_next.p0_high = reg_wdata_i & mpepr_pkg::MASK_P0_HIGH;
            mpepr_pkg::ADDR_P0_LOW: state_next.p0_low = reg_wdata_i;
            default: wmask = 8'hff;
         endcase
      end
      // set wins over a simultaneous clear
      state_next.pending = (state_reg.pending & wmask) | raw_set;
      // registered read data, unmapped addresses read zero
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            mpepr_pkg::ADDR_PENDING: state_next.rd_data = state_reg.pending;
            mpepr_pkg::ADDR_TACHO_HIGH: state_next.rd_data = state_reg.tacho_high;
            mpepr_pkg::ADDR_TACHO_LOW: state_next.rd_data = state_reg.tacho_low;
            mpepr_pkg::ADDR_PWM_DIV: state_next.rd_data = state_reg.pwm_div;
            mpepr_pkg::ADDR_REP: state_next.rd_data = state_reg.update_period_count;
            mpepr_pkg::ADDR_W_HIGH: state_next.rd_data = state_reg.w_high;
            mpepr_pkg::ADDR_W_LOW: state_next.rd_data = state_reg.w_low;
            mpepr_pkg::ADDR_V_HIGH: state_next.rd_data = state_reg.v_high;
            mpepr_pkg::ADDR_V_LOW: state_next.rd_data = state_reg.v_low;
            mpepr_pkg::ADDR_U_HIGH: state_next.rd_data = state_reg.u_high;
            mpepr_pkg::ADDR_U_LOW: state_next.rd_data = state_reg.u_low;
            mpepr_pkg::ADDR_P0_HIGH: state_next.rd_data = state_reg.p0_high;
            mpepr_pkg::ADDR_P0_LOW: state_next.rd_data = state_reg.p0_low;
            default: state_next.rd_data = mpepr_pkg::RESET_BYTE;
         endcase
      end
   end

   // ==========================================================
   // state register, everything zero at reset except xf_state, which loads MPEPR_XF_IDLE
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_reg <= '0;
         state_reg.xf_state <= mpepr_pkg::MPEPR_XF_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // outputs
   assign reg_rdata_o = state_reg.rd_data;
   assign tacho_tick_o = state_reg.tacho_tick;
   assign pwm_tick_o = state_reg.pwm_tick;
   assign transfer_o = state_reg.transfer_pulse;
   assign compare_o = state_reg.cmp;
   assign event_pending_flags_o = state_reg.pending;

   // ==========================================================
   // assertions
   period_flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      events_i.period_match && event_enables_i[7] |=> event_pending_flags_o[7])
      else $error("period match flag not set");
   capture_flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      events_i.tacho_capture && event_enables_i[6] |=> event_pending_flags_o[6])
      else $error("capture flag not set");
   overflow_flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      events_i.tacho_overflow && event_enables_i[5] |=> event_pending_flags_o[5])
      else $error("overflow flag not set");
   transfer_flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      transfer_o && event_enables_i[4] |=> event_pending_flags_o[4])
      else $error("transfer flag not set");
   zero_flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      events_i.pwm_zero && event_enables_i[3] |=> event_pending_flags_o[3])
      else $error("zero flag not set");
   phase_dir_filter_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      counting_shape_select_i && (counting_up_i == direction_event_select_i)
      && !event_pending_flags_o[0] && !(reg_wr_i && reg_addr_i == mpepr_pkg::ADDR_PENDING)
      |=> !event_pending_flags_o[0])
      else $error("phase flag set in wrong direction");
   no_sw_set_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      reg_wr_i && reg_addr_i == mpepr_pkg::ADDR_PENDING && raw_set == 8'h00
      |=> (event_pending_flags_o & ~$past(event_pending_flags_o)) == 8'h00)
      else $error("software raised a pending flag");
   clear_on_zero_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      reg_wr_i && reg_addr_i == mpepr_pkg::ADDR_PENDING |=> event_pending_flags_o
      == (($past(event_pending_flags_o) & $past(reg_wdata_i)) | $past(raw_set)))
      else $error("pending write clear wrong");
   pwm_div_period_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      pwm_tick_o && pwm_enable_i && state_reg.pwm_div == 8'h01
      |=> !pwm_tick_o ##1 (pwm_tick_o || !$past(pwm_enable_i) || $past(state_reg.pwm_div) != 8'h01))
      else $error("pwm prescaler period wrong");
   hw_transfer_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      hw_transfer && state_reg.xf_state == mpepr_pkg::MPEPR_XF_IDLE
      |=> transfer_o && compare_o.p0 == {$past(state_reg.p0_high[1:0]), $past(state_reg.p0_low)})
      else $error("hardware transfer missed");
   reset_zero_a: assert property (@(posedge clk_sys_i)
      $rose(reset_n_i) |-> event_pending_flags_o == 8'h00)
      else $error("pending not zero after reset");
   // a counter zero that is not due for transfer only steps the repetition count down
   rep_count_down_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      !transfer_source_select_i && pwm_enable_i && events_i.pwm_zero && state_reg.rep_count != 8'h00
      && state_reg.xf_state == mpepr_pkg::MPEPR_XF_IDLE |=> !transfer_o
      && state_reg.rep_count == $past(state_reg.rep_count) - 8'h01)
      else $error("repetition count not stepped");
   // a software command leaves the u preload untouched when its enable is off
   sw_mask_hold_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      sw_transfer && state_reg.xf_state == mpepr_pkg::MPEPR_XF_IDLE
      && !software_transfer_enables_i[mpepr_pkg::SEN_U] |=> transfer_o && $stable(compare_o.u))
      else $error("disabled preload copied");
   // a zero tacho divider gives a tick on every cycle
   tacho_zero_div_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      tacho_enable_i && tacho_div == 12'h000 |=> tacho_tick_o)
      else $error("tacho divide by one wrong");
   // reserved compare-0 high bits never stored
   p0_reserved_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      reg_wr_i && reg_addr_i == mpepr_pkg::ADDR_P0_HIGH
      |=> state_reg.p0_high == (mpepr_pkg::MASK_P0_HIGH & $past(reg_wdata_i)))
      else $error("compare-0 reserved bits kept");
   hw_transfer_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) hw_transfer);
   sw_transfer_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) sw_transfer);
   clear_flag_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      reg_wr_i && reg_addr_i == mpepr_pkg::ADDR_PENDING && event_pending_flags_o != 8'h00);
   rep_count_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      events_i.pwm_zero && !transfer_source_select_i && state_reg.rep_count != 8'h00);
   centred_phase_c: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      counting_shape_select_i && events_i.u_match && phase_dir_ok);
endmodule
`default_nettype wire

// ### verif/motor_pwm_event_preload_regs_test.sv
// self-checking testbench of the pwm event/preload register block
`timescale 1ns/1ns
`default_nettype none
module motor_pwm_event_preload_regs_test;
   // ==========================================
   // stimulus and observed signals
   logic clk, reset_n, reg_wr, reg_rd, pwm_en, tacho_en, shape, dir, src, swcmd;
   logic [7:0] reg_addr, reg_wdata, ev_en, rdata, pend;
   logic [4:0] swen;
   logic tacho_tick, pwm_tick, xfer, counting_up;
   mpepr_pkg::mpepr_events_t events;
   mpepr_pkg::mpepr_compare_t cmp, cmp_exp;
   int error_cnt = 0; // mismatches seen
   int tests_run = 0; // comparisons made

   mpepr_top dut (.clk_sys_i(clk), .reset_n_i(reset_n), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
      .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .pwm_enable_i(pwm_en),
      .tacho_enable_i(tacho_en), .counting_shape_select_i(shape), .direction_event_select_i(dir),
      .counting_up_i(counting_up), .transfer_source_select_i(src), .software_transfer_command_i(swcmd),
      .software_transfer_enables_i(swen), .event_enables_i(ev_en), .events_i(events),
      .tacho_tick_o(tacho_tick), .pwm_tick_o(pwm_tick), .transfer_o(xfer), .compare_o(cmp),
      .event_pending_flags_o(pend));
   mpepr_power_stage_model model (.clk_i(clk), .events_o(events), .counting_up_o(counting_up));

   // ==========================================
   // 100 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ==========================================
   // shared tasks: compare, verdict, register bus cycles
   task automatic chk(input string what, input logic [42:0] exp, input logic [42:0] got);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      if (error_cnt == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   // read data is registered, so it is judged one cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk("reg_rdata_o", 43'(exp), 43'(rdata));
   endtask
   // bits that survive a write of all ones; unmapped and pending read back zero
   function automatic logic [7:0] field_mask(input logic [7:0] a);
      case (a)
         8'hf2, 8'hf3: return 8'h00;
         8'hf4: return 8'h0f;
         8'hf9, 8'hfb, 8'hfd: return 8'he0;
         8'hfe: return 8'h03;
         default: return 8'hff;
      endcase
   endfunction
   // bounded wait for the next tick of one prescaler; pick 1 is tacho
   task automatic wait_tick(input logic pick, output int n);
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while ((pick ? tacho_tick : pwm_tick) !== 1'b1 && n < 600);
      if (n >= 600)
      begin
         error_cnt++;
         $display("[FAIL] prescaler tick expected within 600 cycles seen none");
         results();
      end
   endtask
   task automatic gap_chk(input logic pick, input logic [42:0] exp);
      int n;
      wait_tick(pick, n);
      wait_tick(pick, n);
      chk("tick gap", exp, 43'(n));
   endtask

   // ==========================================
   // scenarios
   task automatic sc_reset();
      chk("event_pending_flags_o", 43'h0, 43'(pend));
      chk("compare_o", 43'h0, cmp);
      for (int i = 8'hf3; i <= 8'hff; i++)
         rd_chk(8'(i), 8'h00);
   endtask
   task automatic sc_regs();
      for (int i = 8'hf2; i <= 8'hff; i++)
      begin
         wr(8'(i), 8'hff);
         rd_chk(8'(i), field_mask(8'(i)));
         wr(8'(i), 8'h00);
      end
   endtask
   task automatic sc_flags();
      pwm_en = 1'b1;
      ev_en = 8'hff;
      model.fire(7'h7f, 1'b1);
      @(negedge clk);
      chk("event_pending_flags_o", 43'hff, 43'(pend));
      wr(mpepr_pkg::ADDR_PENDING, 8'hfe);
      chk("event_pending_flags_o", 43'hfe, 43'(pend));
      wr(mpepr_pkg::ADDR_PENDING, 8'hff);
      chk("event_pending_flags_o", 43'hfe, 43'(pend));
      wr(mpepr_pkg::ADDR_PENDING, 8'h00);
      ev_en = 8'h00;
      model.fire(7'h7f, 1'b1);
      @(negedge clk);
      chk("event_pending_flags_o", 43'h00, 43'(pend));
   endtask
   task automatic sc_centred();
      shape = 1'b1;
      ev_en = 8'hff;
      for (int k = 0; k < 4; k++)
      begin
         dir = k[1];
         model.fire(7'b0011100, k[0]);
         @(negedge clk);
         chk("event_pending_flags_o", (k[0] != k[1]) ? 43'h07 : 43'h00, 43'(pend));
         wr(mpepr_pkg::ADDR_PENDING, 8'h00);
      end
      shape = 1'b0;
   endtask
   task automatic sc_hw_xfer();
      logic [7:0] pre [8] = '{8'hab, 8'he0, 8'h12, 8'h40, 8'hff, 8'ha0, 8'h03, 8'h45};
      for (int i = 0; i < 8; i++)
         wr(8'hf8 + 8'(i), pre[i]);
      model.fire(7'b1000000, 1'b1);
      chk("transfer_o", 43'h1, 43'(xfer));
      @(negedge clk);
      cmp_exp = '{u: 11'h7fd, v: 11'h092, w: 11'h55f, p0: 10'h345};
      chk("compare_o", cmp_exp, cmp);
      chk("event_pending_flags_o", 43'h18, 43'(pend));
      wr(mpepr_pkg::ADDR_REP, 8'h01);
      for (int k = 0; k < 3; k++)
      begin
         model.fire(7'b1000000, 1'b1);
         chk("transfer_o", (k == 1) ? 43'h0 : 43'h1, 43'(xfer));
      end
   endtask
   task automatic sc_sw_xfer();
      src = 1'b1;
      swen = 5'b00010;
      wr(mpepr_pkg::ADDR_U_HIGH, 8'h00);
      wr(mpepr_pkg::ADDR_W_HIGH, 8'h00);
      model.fire(7'b1000000, 1'b1);
      chk("transfer_o", 43'h0, 43'(xfer));
      @(negedge clk);
      swcmd = 1'b1;
      @(negedge clk);
      swcmd = 1'b0;
      chk("transfer_o", 43'h1, 43'(xfer));
      @(negedge clk);
      cmp_exp.u = 11'h005;
      chk("compare_o", cmp_exp, cmp);
      // second command: repetition, w, v and compare-0 enabled, u left out
      wr(mpepr_pkg::ADDR_REP, 8'h00);
      swen = 5'b11101;
      @(negedge clk);
      swcmd = 1'b1;
      @(negedge clk);
      swcmd = 1'b0;
      @(negedge clk);
      cmp_exp.w = 11'h007;
      chk("compare_o", cmp_exp, cmp);
      // repetition count copied as zero, so the next counter zero transfers at once
      src = 1'b0;
      model.fire(7'b1000000, 1'b1);
      chk("transfer_o", 43'h1, 43'(xfer));
   endtask
   // dividers only grow here, so a running count never has to wrap
   task automatic sc_prescale();
      tacho_en = 1'b1;
      gap_chk(1'b0, 43'd1);
      gap_chk(1'b1, 43'd1);
      wr(mpepr_pkg::ADDR_PWM_DIV, 8'h01);
      gap_chk(1'b0, 43'd2);
      wr(mpepr_pkg::ADDR_PWM_DIV, 8'h02);
      gap_chk(1'b0, 43'd3);
      wr(mpepr_pkg::ADDR_TACHO_LOW, 8'h02);
      gap_chk(1'b1, 43'd3);
      wr(mpepr_pkg::ADDR_TACHO_HIGH, 8'h01);
      gap_chk(1'b1, 43'd259);
   endtask

   // ==========================================
   // main sequence
   initial
   begin
      {reset_n, reg_wr, reg_rd, pwm_en, tacho_en, shape, dir, src, swcmd} = '0;
      {reg_addr, reg_wdata, ev_en} = '0;
      swen = 5'b00000;
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      sc_reset();
      sc_regs();
      sc_flags();
      sc_centred();
      sc_hw_xfer();
      sc_sw_xfer();
      sc_prescale();
      // reset in mid-run with loaded registers, then everything must read zero again
      @(negedge clk);
      reset_n = 1'b0;
      @(negedge clk);
      reset_n = 1'b1;
      sc_reset();
      results();
   end
endmodule
`default_nettype wire

// ### verif/mpepr_power_stage_model.sv
// far-side model: inverter counter section and tacho sensor as seen by the event inputs
`timescale 1ns/1ns
`default_nettype none
module mpepr_power_stage_model
(
   input wire logic clk_i, // internal core clock
   output mpepr_pkg::mpepr_events_t events_o, // raw counter event pulses
   output logic counting_up_o // counter direction status, 1 up
);
   // ==========================================
   // idle state: no events, counter running up
   initial
   begin
      events_o = '0;
      counting_up_o = 1'b1;
   end

   // ==========================================
   // one-cycle event pulse, launched off the falling edge so the block samples it cleanly
   task automatic fire(input mpepr_pkg::mpepr_events_t ev, input logic up);
      @(negedge clk_i);
      events_o = ev;
      counting_up_o = up;
      @(negedge clk_i);
      events_o = '0;
   endtask
endmodule
`default_nettype wire
